// ### host_far_side.sv
// Model of the external ROM page latch and palette strobe counter
`timescale 1ns/10ps
`default_nettype none
module host_far_side (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Strobes and host data
    input wire logic rom_select_strobe_n,
    input wire logic palette_write_strobe_n,
    input wire logic palette_read_strobe_n,
    input wire logic [7:0] io_wdata,
    // Latched page and palette strobe count
    output logic [2:0] rom_page,
    output logic [7:0] pal_bytes
);
    // ==========================================================
    // Page latch and strobe counter
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rom_page <= 3'h0;
        end else if (!rom_select_strobe_n) begin
            rom_page <= io_wdata[2:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pal_bytes <= 8'h00;
        end else if (!palette_write_strobe_n || !palette_read_strobe_n) begin
            pal_bytes <= pal_bytes + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### io_decode_if.sv
// Address hits passed from the decoder to the port core
`timescale 1ns/10ps
`default_nettype none
interface io_decode_if;
    logic hit_rom_map;
    logic hit_option;
    logic hit_pal;
    logic hit_pal_rd_addr;
    logic hit_pal_wr_addr;
    logic hit_misc;
    modport decoder (output hit_rom_map, hit_option, hit_pal, hit_pal_rd_addr,
        hit_pal_wr_addr, hit_misc);
    modport core (input hit_rom_map, hit_option, hit_pal, hit_pal_rd_addr,
        hit_pal_wr_addr, hit_misc);
endinterface
`default_nettype wire

// ### port_decoder.sv
// Host I/O address decoder
`timescale 1ns/10ps
`default_nettype none
module port_decoder
    import setup_port_pkg::*;
(
    // Host address
    input wire logic [15:0] io_addr,
    // Decoded hits
    io_decode_if.decoder hits
);
    function automatic logic addr_match(input logic [15:0] a, input logic [15:0] base,
        input logic [15:0] mask);
        addr_match = ((a & mask) == (base & mask));
    endfunction

    assign hits.hit_rom_map = addr_match(io_addr, ROM_MAP_ADDR, ROM_MAP_MASK); // [R02]
    assign hits.hit_option = addr_match(io_addr, OPTION_ADDR, FULL_MASK);
    assign hits.hit_pal_rd_addr = addr_match(io_addr, PAL_RD_ADDR, FULL_MASK);
    assign hits.hit_pal_wr_addr = addr_match(io_addr, PAL_WR_ADDR, FULL_MASK);
    assign hits.hit_misc = addr_match(io_addr, MISC_OUT_ADDR, FULL_MASK);
    assign hits.hit_pal = addr_match(io_addr, PAL_MASK_ADDR, FULL_MASK)
        | hits.hit_pal_rd_addr | hits.hit_pal_wr_addr
        | addr_match(io_addr, PAL_DATA_ADDR, FULL_MASK); // [R12]
endmodule
`default_nettype wire

// ### setup_enable_port_decode.sv
// Setup, sleep, palette strobe and clock pin control for the display controller
// How it works
// R01 - Write-only ROM-mapping port at ROM_MAP_SETUP_CONTROL, pc_bus
// R02 - Partial decode: 56E8H, 66E8H, 76E8H alias it
// R03 - Layout: D4 setup, D3 enable, D2:D0 page
// R04 - Only bits 4 and 3 held inside
// R05 - ROM select strobe pulses on port write
// R06 - External logic latches page bits as ROM address
// R07 - No ROM mapping in channel_bus mode
// R08 - Option port OPTION_SELECT_SLEEP; bit0 one means functional
// R09 - Asleep: only setup cycles, no interrupts
// R10 - Host sets setup bit before accessing OPTION_SELECT_SLEEP
// R11 - Channel_bus: card setup select low means setup
// R12 - Palette strobes for ports 3C6H to 3C9H
// R13 - 3C8H write address, PALETTE_ACCESS_STATE read address, 3C6H mask
// R14 - Read of PALETTE_ACCESS_STATE returns palette access state
// R15 - Host moves entries as three data bytes
// R16 - Straps latched from memory data pins 2, 3
// R17 - Bus straps hidden; bits 4-7 readable status
// R18 - Bus strap low channel_bus, high pc_bus
// R19 - Clock strap selects alt clock pin direction
// R20 - Alt clock A pulses low on 3C2 write
// R21 - Alt clock B is third clock select
// R22 - Subsystem enable port 3C3H lives outside
// R23 - Alt clock B driven from control bit 1
// R24 - Outputs mode forces primary dot clock
// R25 - Setup bits clear on reset; sleep bit defined
`timescale 1ns/10ps
`default_nettype none
module setup_enable_port_decode
    import setup_port_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Host I/O cycle
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_rd,
    input wire logic io_wr,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    // Setup select and interrupt
    input wire logic card_setup_select_n,
    input wire logic irq_request,
    output logic irq_out,
    // Straps
    input wire logic [7:0] memory_data_pins,
    output logic [3:0] general_status_bits,
    // Strobes to external logic
    output logic rom_select_strobe_n,
    output logic palette_write_strobe_n,
    output logic palette_read_strobe_n,
    // Device state
    output logic setup_active,
    output logic access_enable,
    output logic device_awake,
    // Alternate clock pins
    input wire logic second_extended_control_b1,
    input wire logic alt_clock_a_in,
    output logic alt_clock_a_out,
    output logic alt_clock_a_oe,
    input wire logic alt_clock_b_in,
    output logic alt_clock_b_out,
    output logic alt_clock_b_oe,
    output logic [1:0] dot_clock_select
);
    // ==========================================================
    // Decode and straps
    io_decode_if hits ();
    logic bus_is_pc;
    logic clk_pins_out;

    port_decoder u_decoder (
        .io_addr(io_addr),
        .hits(hits)
    );

    strap_capture u_straps (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .memory_data_pins(memory_data_pins),
        .bus_is_pc(bus_is_pc),
        .clk_pins_out(clk_pins_out),
        .status_bits(general_status_bits)
    );

    // ==========================================================
    // Internal state
    logic setup_reg;
    logic access_reg;
    logic [7:0] option_reg;
    logic [1:0] pal_state_reg;
    logic [1:0] clk_sel_reg;
    logic setup_mode;
    logic normal_ok;
    logic rom_wr;

    // Setup mode source depends on the bus strap
    assign setup_mode = bus_is_pc ? setup_reg : ~card_setup_select_n; // [R11] [R10]
    // Normal cycles need the awake bit and, on pc_bus, the access enable
    assign normal_ok = option_reg[OPTION_AWAKE_BIT]
        && (bus_is_pc ? access_reg : 1'b1); // [R08] [R09]
    assign rom_wr = io_wr && hits.hit_rom_map && bus_is_pc; // [R01] [R07]

    // ==========================================================
    // ROM-mapping port: only setup and access bits kept
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            setup_reg <= 1'b0; // [R25]
            access_reg <= 1'b0; // [R25]
        end else if (rom_wr) begin
            setup_reg <= io_wdata[ROM_SETUP_BIT]; // [R03] [R04]
            access_reg <= io_wdata[ROM_ACCESS_BIT]; // [R03] [R04]
        end
    end

    // Write strobe so outside logic can take page bits
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rom_select_strobe_n <= 1'b1;
        end else begin
            rom_select_strobe_n <= ~rom_wr; // [R05] [R06]
        end
    end

    // ==========================================================
    // Option-select port, reachable only in setup mode
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            option_reg <= OPTION_RESET; // [R25]
        end else if (io_wr && hits.hit_option && setup_mode) begin
            option_reg <= io_wdata; // [R08] [R10] [R11]
        end
    end

    // ==========================================================
    // Palette access state and strobes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pal_state_reg <= PAL_STATE_RESET;
        end else if (io_wr && normal_ok && hits.hit_pal_rd_addr) begin
            pal_state_reg <= PAL_STATE_READ; // [R13] [R14]
        end else if (io_wr && normal_ok && hits.hit_pal_wr_addr) begin
            pal_state_reg <= PAL_STATE_WRITE; // [R13] [R14]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            palette_write_strobe_n <= 1'b1;
            palette_read_strobe_n <= 1'b1;
        end else begin
            palette_write_strobe_n <= ~(io_wr && normal_ok && hits.hit_pal); // [R12]
            palette_read_strobe_n <= ~(io_rd && normal_ok && hits.hit_pal
                && !hits.hit_pal_rd_addr); // [R12] [R14]
        end
    end

    // ==========================================================
    // Internal read answers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            io_rdata <= 8'h00;
            io_rdata_valid <= 1'b0;
        end else if (io_rd && hits.hit_option && setup_mode) begin
            io_rdata <= option_reg; // [R08]
            io_rdata_valid <= 1'b1;
        end else if (io_rd && hits.hit_pal_rd_addr && normal_ok) begin
            io_rdata <= {PAL_STATE_RSVD, pal_state_reg}; // [R14]
            io_rdata_valid <= 1'b1;
        end else begin
            io_rdata <= 8'h00;
            io_rdata_valid <= 1'b0;
        end
    end

    // ==========================================================
    // Status outputs and interrupt gating
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            setup_active <= 1'b0;
            access_enable <= 1'b0;
            device_awake <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            setup_active <= setup_mode;
            access_enable <= access_reg;
            device_awake <= option_reg[OPTION_AWAKE_BIT];
            irq_out <= irq_request && option_reg[OPTION_AWAKE_BIT]; // [R09]
        end
    end

    // ==========================================================
    // Clock pins and dot clock selection
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            clk_sel_reg <= 2'h0;
        end else if (io_wr && normal_ok && hits.hit_misc) begin
            clk_sel_reg <= io_wdata[MISC_CLK_HI_BIT:MISC_CLK_LO_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            alt_clock_a_out <= 1'b1;
            alt_clock_b_out <= 1'b0;
            alt_clock_a_oe <= 1'b0;
            alt_clock_b_oe <= 1'b0;
        end else begin
            alt_clock_a_out <= ~(io_wr && normal_ok && hits.hit_misc); // [R20]
            alt_clock_b_out <= second_extended_control_b1; // [R21] [R23]
            alt_clock_a_oe <= clk_pins_out; // [R19]
            alt_clock_b_oe <= clk_pins_out; // [R19]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dot_clock_select <= DOT_PRIMARY;
        end else if (clk_pins_out) begin
            dot_clock_select <= DOT_PRIMARY; // [R24]
        end else if (clk_sel_reg[1]) begin
            dot_clock_select <= DOT_ALT_B; // [R19]
        end else if (clk_sel_reg[0]) begin
            dot_clock_select <= DOT_ALT_A; // [R19]
        end else begin
            dot_clock_select <= DOT_PRIMARY;
        end
    end

    // ==========================================================
    // Assertions
    chk_rom_strobe_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // [R05]
        (io_wr && hits.hit_rom_map && bus_is_pc) |=> !rom_select_strobe_n)
        else $error("ROM select strobe missing after mapping port write");
    chk_rom_channel_idle: assert property (@(posedge ref_clk) disable iff (!nrst) // [R07]
        (!bus_is_pc && $stable(bus_is_pc)) |=> rom_select_strobe_n)
        else $error("ROM select strobe in channel bus mode");
    chk_setup_bit_load: assert property (@(posedge ref_clk) disable iff (!nrst) // [R04]
        rom_wr |=> (setup_reg == $past(io_wdata[4]) && access_reg == $past(io_wdata[3])))
        else $error("Mapping port bits not captured");
    chk_option_gate: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
        (io_wr && hits.hit_option && !setup_mode) |=> $stable(option_reg))
        else $error("Option port written outside setup mode");
    chk_sleep_quiet: assert property (@(posedge ref_clk) disable iff (!nrst) // [R09]
        (!option_reg[0] && $stable(option_reg)) |=> (palette_write_strobe_n
        && palette_read_strobe_n && !irq_out))
        else $error("Activity while asleep");
    chk_channel_setup: assert property (@(posedge ref_clk) disable iff (!nrst) // [R11]
        (!bus_is_pc && !card_setup_select_n) |=> setup_active)
        else $error("Setup select low did not give setup mode");
    chk_pal_state_read: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
        (io_rd && hits.hit_pal_rd_addr && normal_ok) |=> (io_rdata_valid
        && io_rdata[7:2] == 6'h00 && palette_read_strobe_n))
        else $error("Palette state read answered wrongly");
    chk_pal_state_seq: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
        (io_wr && normal_ok && hits.hit_pal_rd_addr) |=> (pal_state_reg == 2'h3))
        else $error("Palette state not set to read");
    chk_load_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // [R20]
        (io_wr && normal_ok && hits.hit_misc) |=> !alt_clock_a_out ##1 alt_clock_a_out
        || (io_wr && normal_ok && hits.hit_misc))
        else $error("Load pulse shape wrong");
    chk_clk_b_level: assert property (@(posedge ref_clk) disable iff (!nrst) // [R23]
        1'b1 |=> (alt_clock_b_out == $past(second_extended_control_b1)))
        else $error("Alt clock B level does not follow control bit");
    chk_mux_forced: assert property (@(posedge ref_clk) disable iff (!nrst) // [R24]
        (clk_pins_out && $stable(clk_pins_out)) |=> (dot_clock_select == DOT_PRIMARY))
        else $error("Dot clock not forced to primary");
    chk_reset_clear: assert property (@(posedge ref_clk) // [R25]
        !nrst |=> (!setup_reg && !access_reg && option_reg == OPTION_RESET))
        else $error("Reset values wrong");

    // ==========================================================
    // Strobe, read, strap, interrupt and dot clock checks
    chk_pal_write_strobe: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
        (io_wr && normal_ok && hits.hit_pal) |=> !palette_write_strobe_n)
        else $error("Palette write strobe missing");
    chk_pal_read_strobe: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
        (io_rd && normal_ok && hits.hit_pal && !hits.hit_pal_rd_addr)
        |=> !palette_read_strobe_n)
        else $error("Palette read strobe missing");
    chk_option_read: assert property (@(posedge ref_clk) disable iff (!nrst) // [R08]
        (io_rd && hits.hit_option && setup_mode)
        |=> (io_rdata_valid && io_rdata == $past(option_reg)))
        else $error("Option port read answered wrongly");
    chk_straps_frozen: assert property (@(posedge ref_clk) disable iff (!nrst) // [R16]
        1'b1 |=> ($stable(bus_is_pc) && $stable(clk_pins_out)))
        else $error("Straps changed outside reset");
    chk_irq_gate: assert property (@(posedge ref_clk) disable iff (!nrst) // [R09]
        (irq_request && option_reg[OPTION_AWAKE_BIT]) |=> irq_out)
        else $error("Interrupt lost while awake");
    chk_dot_alt_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R19]
        (!clk_pins_out && clk_sel_reg == 2'h1) |=> (dot_clock_select == DOT_ALT_A))
        else $error("Dot clock not set to alternate A");

    cov_pc_setup_wake: cover property (@(posedge ref_clk) disable iff (!nrst)
        rom_wr ##[1:20] (io_wr && hits.hit_option && setup_mode));
    cov_pal_read_seq: cover property (@(posedge ref_clk) disable iff (!nrst)
        (io_wr && hits.hit_pal_rd_addr && normal_ok) ##[1:20]
        (io_rd && hits.hit_pal_rd_addr && normal_ok));
    cov_load_pulse: cover property (@(posedge ref_clk) disable iff (!nrst)
        !alt_clock_a_out && alt_clock_a_oe);
    cov_channel_setup: cover property (@(posedge ref_clk) disable iff (!nrst)
        !bus_is_pc && setup_active);
endmodule
`default_nettype wire

// ### setup_enable_port_decode_bench.sv
// Self-checking bench for the setup, sleep and palette port decode
`timescale 1ns/10ps
`default_nettype none
module setup_enable_port_decode_bench import setup_port_pkg::*;;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic w;
        logic [15:0] a;
        logic [7:0] d;
        logic [4:0] e;
        logic [7:0] r;
    } row_t;
    logic ref_clk = 1'b0, nrst = 1'b0, io_rd = 1'b0, io_wr = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00, memory_data_pins = 8'hAC, io_rdata, rdv;
    logic card_setup_select_n = 1'b1, irq_request = 1'b0, sec_b1 = 1'b0;
    logic io_rdata_valid, irq_out, setup_active, access_enable, device_awake;
    logic rom_select_strobe_n, palette_write_strobe_n, palette_read_strobe_n;
    logic alt_clock_a_out, alt_clock_a_oe, alt_clock_b_out, alt_clock_b_oe;
    logic [3:0] general_status_bits;
    logic [1:0] dot_clock_select;
    logic [2:0] rom_page;
    logic [7:0] pal_bytes;
    logic [4:0] obs;
    wire logic alt_a_pin = alt_clock_a_oe ? alt_clock_a_out : 1'b0;
    wire logic alt_b_pin = alt_clock_b_oe ? alt_clock_b_out : 1'b0;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    row_t rows [19];
    // ==========================================================
    // Design and far side
    setup_enable_port_decode i_setup_enable_port_decode (.ref_clk(ref_clk), .nrst(nrst),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .card_setup_select_n(card_setup_select_n), .irq_request(irq_request),
        .irq_out(irq_out), .memory_data_pins(memory_data_pins),
        .general_status_bits(general_status_bits), .rom_select_strobe_n(rom_select_strobe_n),
        .palette_write_strobe_n(palette_write_strobe_n),
        .palette_read_strobe_n(palette_read_strobe_n), .setup_active(setup_active),
        .access_enable(access_enable), .device_awake(device_awake),
        .second_extended_control_b1(sec_b1), .alt_clock_a_in(alt_a_pin),
        .alt_clock_a_out(alt_clock_a_out), .alt_clock_a_oe(alt_clock_a_oe),
        .alt_clock_b_in(alt_b_pin), .alt_clock_b_out(alt_clock_b_out),
        .alt_clock_b_oe(alt_clock_b_oe), .dot_clock_select(dot_clock_select));
    host_far_side i_host_far_side (.ref_clk(ref_clk), .nrst(nrst),
        .rom_select_strobe_n(rom_select_strobe_n), .palette_write_strobe_n(palette_write_strobe_n),
        .palette_read_strobe_n(palette_read_strobe_n), .io_wdata(io_wdata),
        .rom_page(rom_page), .pal_bytes(pal_bytes));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    endtask
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        io_wr <= w;
        io_rd <= !w;
        io_addr <= a;
        io_wdata <= d;
        @(posedge ref_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1;
        obs = {rom_select_strobe_n, palette_write_strobe_n, palette_read_strobe_n,
            alt_clock_a_out, io_rdata_valid};
        rdv = io_rdata;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic rst(input logic [7:0] pins);
        @(posedge ref_clk);
        nrst <= 1'b0;
        memory_data_pins <= pins;
        repeat (11) @(posedge ref_clk);
        #1;
        chk({rom_select_strobe_n, palette_write_strobe_n, palette_read_strobe_n,
            alt_clock_a_out, alt_clock_a_oe, setup_active, access_enable, device_awake},
            8'hF0);
        @(posedge ref_clk);
        nrst <= 1'b1;
        memory_data_pins <= ~pins;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Clock and timeout
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        rows = '{'{1, 16'h46E8, 8'h1D, 5'h0E, 8'h00}, '{1, 16'h56E8, 8'h18, 5'h0E, 8'h00},
            '{1, 16'h66E8, 8'h18, 5'h0E, 8'h00}, '{1, 16'h76E8, 8'h1D, 5'h0E, 8'h00},
            '{1, 16'h46E9, 8'h18, 5'h1E, 8'h00}, '{0, 16'h46E8, 8'h00, 5'h1E, 8'h00},
            '{1, 16'h0102, 8'h01, 5'h1E, 8'h00}, '{0, 16'h0102, 8'h00, 5'h1F, 8'h01},
            '{1, 16'h03C7, 8'h00, 5'h16, 8'h00}, '{0, 16'h03C7, 8'h00, 5'h1F, 8'h03},
            '{1, 16'h03C8, 8'h00, 5'h16, 8'h00}, '{0, 16'h03C7, 8'h00, 5'h1F, 8'h00},
            '{1, 16'h03C6, 8'hFF, 5'h16, 8'h00}, '{0, 16'h03C6, 8'h00, 5'h1A, 8'h00},
            '{1, 16'h03C9, 8'h11, 5'h16, 8'h00}, '{1, 16'h03C9, 8'h22, 5'h16, 8'h00},
            '{1, 16'h03C9, 8'h33, 5'h16, 8'h00}, '{0, 16'h03C9, 8'h00, 5'h1A, 8'h00},
            '{1, 16'h03C2, 8'h08, 5'h1C, 8'h00}};
        rst(8'hAC);
        chk({general_status_bits, alt_clock_a_oe, alt_clock_b_oe, dot_clock_select},
            8'h5C);
        chk({setup_active, access_enable, device_awake}, 8'h01);
        @(posedge ref_clk);
        sec_b1 <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(alt_clock_b_out, 1'b1);
        $display("test reset and straps done");
        for (int i = 0; i < 19; i++) begin
            io(rows[i].w, rows[i].a, rows[i].d);
            chk(obs, rows[i].e);
            chk(rdv, rows[i].r);
        end
        chk(rom_page, 3'h5);
        chk(pal_bytes, 8'h08);
        chk({setup_active, access_enable, dot_clock_select}, 8'h0C);
        $display("test row table done");
        @(posedge ref_clk);
        irq_request <= 1'b1;
        io(1, 16'h0102, 8'h00);
        chk({device_awake, irq_out}, 8'h00);
        io(1, 16'h03C9, 8'h44);
        chk(obs, 5'h1E);
        io(0, 16'h03C7, 8'h00);
        chk(obs, 5'h1E);
        io(1, 16'h0102, 8'h01);
        chk({device_awake, irq_out}, 8'h03);
        @(posedge ref_clk);
        irq_request <= 1'b0;
        $display("test sleep done");
        io(1, 16'h46E8, 8'h08);
        io(1, 16'h0102, 8'h00);
        chk({setup_active, access_enable, device_awake}, 8'h03);
        io(1, 16'h46E8, 8'h10);
        io(1, 16'h03C9, 8'h55);
        chk(obs, 5'h1E);
        $display("test setup gating done");
        rst(8'h00);
        chk({general_status_bits, alt_clock_a_oe, alt_clock_b_oe}, 8'h3C);
        io(1, 16'h46E8, 8'h18);
        chk(obs, 5'h1E);
        io(1, 16'h0102, 8'h00);
        chk(device_awake, 1'b1);
        @(posedge ref_clk);
        card_setup_select_n <= 1'b0;
        io(1, 16'h0102, 8'h00);
        chk({setup_active, device_awake}, 8'h02);
        io(1, 16'h03C9, 8'h66);
        chk(obs, 5'h1E);
        io(1, 16'h0102, 8'h01);
        @(posedge ref_clk);
        card_setup_select_n <= 1'b1;
        io(1, 16'h03C9, 8'h77);
        chk(obs, 5'h16);
        io(1, 16'h03C3, 8'h00);
        chk(obs, 5'h1E);
        io(0, 16'h03C3, 8'h00);
        chk(obs, 5'h1E);
        chk(rdv, 8'h00);
        for (int k = 0; k < 4; k++) begin
            io(1, 16'h03C2, 8'(k * 4));
            chk({obs, dot_clock_select}, {5'h1C, (k > 1) ? 2'h2 : 2'(k)});
        end
        $display("test channel mode done");
        conclude();
    end
endmodule
`default_nettype wire

// ### setup_port_pkg.sv
// Constants for the setup, sleep and palette port decode
package setup_port_pkg;
    // ==========================================================
    // Port addresses and decode masks
    localparam logic [15:0] ROM_MAP_ADDR = 16'h46E8;
    localparam logic [15:0] ROM_MAP_MASK = 16'hCFFF;
    localparam logic [15:0] OPTION_ADDR = 16'h0102;
    localparam logic [15:0] PAL_MASK_ADDR = 16'h03C6;
    localparam logic [15:0] PAL_RD_ADDR = 16'h03C7;
    localparam logic [15:0] PAL_WR_ADDR = 16'h03C8;
    localparam logic [15:0] PAL_DATA_ADDR = 16'h03C9;
    localparam logic [15:0] MISC_OUT_ADDR = 16'h03C2;
    localparam logic [15:0] FULL_MASK = 16'hFFFF;
    // ==========================================================
    // Field positions
    localparam int ROM_SETUP_BIT = 4;
    localparam int ROM_ACCESS_BIT = 3;
    localparam int OPTION_AWAKE_BIT = 0;
    localparam int MISC_CLK_LO_BIT = 2;
    localparam int MISC_CLK_HI_BIT = 3;
    localparam int STRAP_BUS_BIT = 2;
    localparam int STRAP_CLKDIR_BIT = 3;
    // ==========================================================
    // Reset values and palette state codes
    localparam logic [7:0] OPTION_RESET = 8'h01;
    localparam logic [1:0] PAL_STATE_RESET = 2'h0;
    localparam logic [1:0] PAL_STATE_READ = 2'h3;
    localparam logic [1:0] PAL_STATE_WRITE = 2'h0;
    localparam logic [5:0] PAL_STATE_RSVD = 6'h00;
    // ==========================================================
    // Dot clock multiplexer selections
    typedef enum logic [1:0] {
        DOT_PRIMARY = 2'h0,
        DOT_ALT_A = 2'h1,
        DOT_ALT_B = 2'h2
    } dot_sel_t;
endpackage

// ### strap_capture.sv
// Power-on strap capture from the memory data pins
`timescale 1ns/10ps
`default_nettype none
module strap_capture
    import setup_port_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Strap pins
    input wire logic [7:0] memory_data_pins,
    // Latched straps
    output logic bus_is_pc,
    output logic clk_pins_out,
    output logic [3:0] status_bits
);
    // Pins are followed while reset is held; the last value before release stays
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bus_is_pc <= memory_data_pins[STRAP_BUS_BIT]; // [R16] [R18]
            clk_pins_out <= memory_data_pins[STRAP_CLKDIR_BIT]; // [R16] [R19]
            status_bits <= ~memory_data_pins[7:4]; // [R17]
        end
    end
endmodule
`default_nettype wire
